// File: hw/ext_control_input_decoder.sv
// External control input decoder with AXI4-Lite control and status registers
`timescale 1ns/1ps
`default_nettype none
module ext_control_input_decoder
  import ext_input_pkg::*;
#(
  parameter logic [CAL_CNT_W-1:0] VCAL_CYCLES = VCAL_CYCLES_DEF,
  parameter logic [CAL_CNT_W-1:0] RCAL_CYCLES = RCAL_CYCLES_DEF
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Isolated control pins, asynchronous
  input  wire ext_inputs_s ext_in,
  // Measurement engine, same clock
  input  wire logic        measure_done,
  input  wire logic        zero_done,
  // Front panel events, same clock, one-cycle pulses
  input  wire logic [7:0]  key_event,
  input  wire logic        touch_event,
  input  wire logic        trigger_key_event,
  output logic [7:0]       key_event_gated,
  output logic             touch_event_gated,
  output logic             trigger_key_gated,
  // Commands to the instrument
  output commands_s        cmd,
  output activity_e        activity,
  output logic             panel_lockout
);

  // ---------------------------------------------------------------
  // Input synchroniser and edge detection
  // ---------------------------------------------------------------
  logic [IN_W-1:0] sync_meta;
  logic [IN_W-1:0] sync_q;
  logic [IN_W-1:0] sync_prev;
  ext_inputs_s     pins;
  ext_inputs_s     rise;

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync_meta[gi] <= 1'b0;
          sync_q[gi]    <= 1'b0;
          sync_prev[gi] <= 1'b0;
        end
        else
        begin
          sync_meta[gi] <= ext_in[gi];
          sync_q[gi]    <= sync_meta[gi];
          sync_prev[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  assign pins = ext_inputs_s'(sync_q);
  assign rise = ext_inputs_s'(sync_q & ~sync_prev);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic              origin_ext;
  logic              meas_accept;
  logic              vcal_auto;

  assign origin_ext  = ctrl[CTRL_ORIGIN_EXT];
  assign vcal_auto   = ctrl[CTRL_VCAL_AUTO];
  // Output or batch transfer also need the pin even with internal origin
  assign meas_accept = origin_ext | ctrl[CTRL_OUTPUT_FN] | ctrl[CTRL_BATCH];

  // ---------------------------------------------------------------
  // Activity sequencer
  // ---------------------------------------------------------------
  activity_e            state;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic [2:0]           last_code;
  logic [2:0]           loaded_panel;
  logic                 can_preempt;
  logic                 go_rcal;
  logic                 go_vcal;
  logic                 go_zero;
  logic                 go_meas;
  logic                 code_changed;
  logic                 code_valid;

  // Calibration edges are ignored while a calibration or zero adjust runs
  assign can_preempt  = (state == ACT_IDLE) || (state == ACT_MEASURE);
  assign go_rcal      = can_preempt && rise.resistance_selfcal;
  assign go_vcal      = can_preempt && rise.voltage_selfcal && vcal_auto && !go_rcal;
  assign go_zero      = can_preempt && rise.zero_adjust && !go_rcal && !go_vcal;
  assign go_meas      = (state == ACT_IDLE) && rise.measure_start && meas_accept
                        && !go_rcal && !go_vcal && !go_zero;
  assign code_changed = pins.panel_select != last_code;
  assign code_valid   = (pins.panel_select >= PANEL_FIRST)
                        && (pins.panel_select <= PANEL_LAST);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ACT_IDLE;
    end
    else
    begin
      unique case (state)
        ACT_IDLE, ACT_MEASURE:
        begin
          if (go_rcal)
            state <= ACT_RCAL;
          else if (go_vcal)
            state <= ACT_VCAL;
          else if (go_zero)
            state <= ACT_ZERO;
          else if (go_meas)
            state <= ACT_MEASURE;
          else if ((state == ACT_MEASURE) && measure_done)
            state <= ACT_IDLE;
        end
        ACT_ZERO:
        begin
          if (zero_done)
            state <= ACT_IDLE;
        end
        ACT_VCAL, ACT_RCAL:
        begin
          if (cal_cnt == '0)
            state <= ACT_IDLE;
        end
        default:
        begin
          state <= ACT_IDLE;
        end
      endcase
    end
  end

  // Counts the calibration time down to zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cal_cnt <= '0;
    else if (go_rcal)
      cal_cnt <= RCAL_CYCLES - CAL_CNT_W'(1);
    else if (go_vcal)
      cal_cnt <= VCAL_CYCLES - CAL_CNT_W'(1);
    else if (cal_cnt != '0)
      cal_cnt <= cal_cnt - CAL_CNT_W'(1);
  end

  // Panel code memory, updated on every accepted measure-start edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_code    <= CODE_RESET;
      loaded_panel <= CODE_RESET;
    end
    else if (go_meas)
    begin
      last_code <= pins.panel_select;
      if (code_changed && code_valid)
        loaded_panel <= pins.panel_select;
    end
  end

  // Command pulses, one cycle each; panel_number follows the code every cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd <= '0;
    end
    else
    begin
      cmd.measure_start      <= go_meas;
      cmd.zero_adjust        <= go_zero;
      cmd.voltage_selfcal    <= go_vcal;
      cmd.resistance_selfcal <= go_rcal;
      cmd.measure_abort      <= (state == ACT_MEASURE)
                                && (go_rcal || go_vcal || go_zero);
      cmd.panel_load         <= go_meas && code_changed && code_valid;
      cmd.panel_number       <= pins.panel_select;
    end
  end

  assign activity = state;

  // ---------------------------------------------------------------
  // Front panel lockout
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      panel_lockout     <= 1'b0;
      key_event_gated   <= 8'h00;
      touch_event_gated <= 1'b0;
      trigger_key_gated <= 1'b0;
    end
    else
    begin
      // Follows the level, so only the controller releasing the pin unlocks
      panel_lockout     <= pins.lockout;
      key_event_gated   <= pins.lockout ? 8'h00 : key_event;
      touch_event_gated <= touch_event && !pins.lockout;
      trigger_key_gated <= trigger_key_event;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl         <= CTRL_RESET[CTRL_W-1:0];
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr == CTRL_OFFSET)
        begin
          s_axi_bresp <= RESP_OKAY;
          if (wr_strb[0])
            ctrl <= wr_data[CTRL_W-1:0];
        end
        else if (wr_addr == STATUS_OFFSET)
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_STATE_LSB +: 3] = state;
    status_word[STAT_LOCKOUT]        = panel_lockout;
    status_word[STAT_CODE_LSB +: 3]  = last_code;
    status_word[STAT_PANEL_LSB +: 3] = loaded_panel;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == CTRL_OFFSET)
        s_axi_rdata <= {{(32-CTRL_W){1'b0}}, ctrl};
      else if (s_axi_araddr == STATUS_OFFSET)
        s_axi_rdata <= status_word;
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : ext_control_input_decoder
`default_nettype wire

// File: hw/ext_input_pkg.sv
// Constants, types and register map for the external control input decoder
// Function
// - Measure-start rising edge begins one measurement
// - Measure-start accepted with external origin
// - Output or batch function also accepts edges
// - Zero-adjust rising edge performs one zero adjustment
// - Zero-adjust during measurement abandons the measurement
// - Voltage-cal edge starts self-cal when automatic
// - Voltage self-calibration lasts about ten seconds
// - Resistance-cal rising edge starts resistance self-cal
// - Resistance self-calibration lasts about 45 seconds
// - Resistance-cal during measurement stops that measurement
// - Lockout ignores keys and touch except trigger
// - Lockout clears only when input goes inactive
// - Panel code then measure-start loads panel, measures
// - Panel code is binary, bit zero least significant
// - Unchanged code since last edge loads no panel
// - Unchanged code with external origin measures once
package ext_input_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam longint unsigned VCAL_TIME_S   = 10;
  localparam longint unsigned RCAL_TIME_S   = 45;
  localparam int              CAL_CNT_W     = 33;
  localparam logic [CAL_CNT_W-1:0] VCAL_CYCLES_DEF = CAL_CNT_W'(VCAL_TIME_S * CLK_HZ);
  localparam logic [CAL_CNT_W-1:0] RCAL_CYCLES_DEF = CAL_CNT_W'(RCAL_TIME_S * CLK_HZ);

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int          CTRL_ORIGIN_EXT = 0;
  localparam int          CTRL_OUTPUT_FN  = 1;
  localparam int          CTRL_BATCH      = 2;
  localparam int          CTRL_VCAL_AUTO  = 3;
  localparam int          CTRL_W          = 4;
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_LOCKOUT    = 3;
  localparam int          STAT_CODE_LSB   = 4;
  localparam int          STAT_PANEL_LSB  = 8;
  localparam logic [2:0]  CODE_RESET      = 3'h0;
  localparam logic [2:0]  PANEL_FIRST     = 3'h1;
  localparam logic [2:0]  PANEL_LAST      = 3'h6;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  localparam int IN_W = 8;

  typedef struct packed {
    logic [2:0] panel_select;
    logic       lockout;
    logic       resistance_selfcal;
    logic       voltage_selfcal;
    logic       zero_adjust;
    logic       measure_start;
  } ext_inputs_s;

  typedef struct packed {
    logic       measure_start;
    logic       zero_adjust;
    logic       voltage_selfcal;
    logic       resistance_selfcal;
    logic       measure_abort;
    logic       panel_load;
    logic [2:0] panel_number;
  } commands_s;

  typedef enum logic [2:0] {
    ACT_IDLE    = 3'b000,
    ACT_MEASURE = 3'b001,
    ACT_ZERO    = 3'b010,
    ACT_VCAL    = 3'b011,
    ACT_RCAL    = 3'b100
  } activity_e;

endpackage : ext_input_pkg

// File: test/ext_control_input_decoder_tb.sv
// Bench for the external control input decoder
`timescale 1ns/1ps
`default_nettype none
module ext_control_input_decoder_tb;
  import ext_input_pkg::*;
  localparam logic [CAL_CNT_W-1:0] VC_N = 33'h14;
  localparam logic [CAL_CNT_W-1:0] RC_N = 33'h28;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, measure_done, zero_done;
  logic        touch_event, trigger_key_event, touch_gated, tkey_gated, lockout;
  logic [7:0]  awaddr, araddr, key_event, key_gated;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  last_panel;
  ext_inputs_s ext_in;
  commands_s   cmd;
  activity_e   activity;
  int          err_count, checks, n_start, n_load, n_abort, n_zero, n_cal, cal_cyc, s, e;
  int          codes[11] = '{1, 2, 3, 4, 5, 6, 7, 0, 0, 5, 5};
  plc_model plc_u (.aclk(aclk), .ext_in(ext_in));
  ext_control_input_decoder #(.VCAL_CYCLES(VC_N), .RCAL_CYCLES(RC_N)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_in(ext_in), .measure_done(measure_done), .zero_done(zero_done),
    .key_event(key_event), .touch_event(touch_event), .trigger_key_event(trigger_key_event),
    .key_event_gated(key_gated), .touch_event_gated(touch_gated),
    .trigger_key_gated(tkey_gated), .cmd(cmd), .activity(activity), .panel_lockout(lockout));
  // ----------
  // Monitor and tasks
  // ----------
  always @(posedge aclk)
  begin
    n_start += int'(cmd.measure_start);
    n_load += int'(cmd.panel_load);
    n_abort += int'(cmd.measure_abort);
    n_zero += int'(cmd.zero_adjust);
    n_cal += int'(cmd.voltage_selfcal) + int'(cmd.resistance_selfcal);
    cal_cyc += int'(activity inside {ACT_VCAL, ACT_RCAL});
    if (cmd.panel_load) last_panel = cmd.panel_number;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] sb = 4'hF);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= sb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic done_meas(input logic z);
    measure_done <= !z;
    zero_done <= z;
    @(posedge aclk);
    measure_done <= 1'b0;
    zero_done <= 1'b0;
    @(posedge aclk);
  endtask : done_meas
  task automatic keys(input logic lk, input logic [7:0] kv);
    @(posedge aclk);
    key_event <= kv;
    touch_event <= kv[0];
    trigger_key_event <= kv[7];
    @(posedge aclk);
    key_event <= 8'h00;
    touch_event <= 1'b0;
    trigger_key_event <= 1'b0;
    #1;
    chk(32'(key_gated), lk ? 32'h0 : 32'(kv), "key gate");
    chk(32'(touch_gated), 32'(kv[0] && !lk), "touch gate");
    chk(32'(tkey_gated), 32'(kv[7]), "trigger key");
  endtask : keys
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // ----------
  // Clock, watchdog, tests
  // ----------
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    err_count++;
    $display("[FAIL] %0t timeout", $time);
    complete_run;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, measure_done, zero_done} = '0;
    {touch_event, trigger_key_event, awaddr, araddr, key_event, wdata, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFFSET);
    chk(d, CTRL_RESET, "ctrl reset");
    wr(CTRL_OFFSET, 32'hFFFF_FFFF);
    rd(CTRL_OFFSET);
    chk(d, 32'h0000_000F, "ctrl mask");
    wr(8'h10, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    rd(8'h10);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    wr(STATUS_OFFSET, 32'h0);
    chk(32'(r), 32'(RESP_OKAY), "status write");
    wr(CTRL_OFFSET, 32'h0);
    s = n_start;
    plc_u.pulse(0);
    chk(n_start, s, "start ignored");
    for (int b = 0; b < 3; b++)
    begin
      wr(CTRL_OFFSET, 32'(1 << b));
      plc_u.pulse(0);
      chk(n_start, s + b + 1, "start once");
      done_meas(1'b0);
    end
    $display("origin test done");
    wr(CTRL_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h0, 4'hE);
    rd(CTRL_OFFSET);
    chk(d, 32'h0000_0001, "strobe kept");
    for (int i = 0; i < 11; i++)
    begin
      s = n_load;
      e = n_start;
      plc_u.code(3'(codes[i]));
      plc_u.pulse(0);
      chk(n_start, e + 1, "start each");
      e = int'(codes[i] != (i ? codes[i-1] : 0) && codes[i] inside {[1:6]});
      chk(n_load, s + e, "panel load");
      if (e) chk(32'(last_panel), codes[i], "panel number");
      rd(STATUS_OFFSET);
      chk(32'(d[6:4]), codes[i], "code kept");
      done_meas(1'b0);
    end
    $display("panel test done");
    s = n_abort;
    plc_u.pulse(0);
    plc_u.pulse(1);
    chk(n_abort, s + 1, "zero abort");
    chk(32'(activity), 32'(ACT_ZERO), "zero state");
    done_meas(1'b1);
    plc_u.pulse(2);
    chk(n_cal, 0, "vcal manual");
    wr(CTRL_OFFSET, 32'h9);
    for (int k = 0; k < 2; k++)
    begin
      s = n_abort;
      plc_u.pulse(0);
      cal_cyc = 0;
      plc_u.pulse(2 + k);
      repeat (50) @(posedge aclk);
      chk(n_abort, s + 1, "cal abort");
      chk(n_cal, k + 1, "cal started");
      e = k ? int'(RC_N) : int'(VC_N);
      chk(32'(cal_cyc >= e && cal_cyc <= e + 1), 32'h1, "cal time");
    end
    $display("preempt test done");
    plc_u.lock(1'b1);
    chk(32'(lockout), 32'h1, "lock pin");
    rd(STATUS_OFFSET);
    chk(32'(d[3]), 32'h1, "status lock");
    keys(1'b1, 8'hA5);
    plc_u.lock(1'b0);
    chk(32'(lockout), 32'h0, "lock released");
    keys(1'b0, 8'h81);
    keys(1'b0, 8'h5A);
    $display("lockout test done");
    complete_run;
  end
endmodule : ext_control_input_decoder_tb
`default_nettype wire

// File: test/ext_decoder_properties.sv
// Port assertions for the external control input decoder
`timescale 1ns/1ps
`default_nettype none
module ext_decoder_properties
  import ext_input_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] key_event,
  input wire logic       touch_event,
  input wire logic [7:0] key_event_gated,
  input wire logic       touch_event_gated,
  input wire commands_s  cmd,
  input wire activity_e  activity,
  input wire logic       panel_lockout
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_st;
    cmd.measure_start |-> activity == ACT_MEASURE && $past(activity) == ACT_IDLE;
  endproperty
  a_st: assert property (p_st) else $error("bad start");
  property p_za;
    cmd.zero_adjust && $past(activity) == ACT_MEASURE |-> cmd.measure_abort;
  endproperty
  a_za: assert property (p_za) else $error("zero no abort");
  property p_va;
    cmd.voltage_selfcal && $past(activity) == ACT_MEASURE |-> cmd.measure_abort;
  endproperty
  a_va: assert property (p_va) else $error("vcal no abort");
  property p_ra;
    cmd.resistance_selfcal && $past(activity) == ACT_MEASURE |-> cmd.measure_abort;
  endproperty
  a_ra: assert property (p_ra) else $error("rcal no abort");
  // Only the opening stretch is held; the full length is timed by the bench
  property p_vt;
    $rose(activity == ACT_VCAL) |-> (activity == ACT_VCAL) [*8];
  endproperty
  a_vt: assert property (p_vt) else $error("vcal too short");
  property p_rt;
    $rose(activity == ACT_RCAL) |-> (activity == ACT_RCAL) [*8];
  endproperty
  a_rt: assert property (p_rt) else $error("rcal too short");
  property p_lk;
    panel_lockout |-> key_event_gated == 8'h00 && !touch_event_gated;
  endproperty
  a_lk: assert property (p_lk) else $error("key passed in lock");
  property p_ul;
    !panel_lockout && $past(aresetn) |-> key_event_gated == $past(key_event)
      && touch_event_gated == $past(touch_event);
  endproperty
  a_ul: assert property (p_ul) else $error("key lost unlocked");
  property p_pn;
    cmd.panel_load |-> cmd.measure_start && cmd.panel_number inside {[PANEL_FIRST:PANEL_LAST]};
  endproperty
  a_pn: assert property (p_pn) else $error("bad panel load");
endmodule : ext_decoder_properties
bind ext_control_input_decoder ext_decoder_properties chk_u (
  .aclk(aclk), .aresetn(aresetn), .key_event(key_event), .touch_event(touch_event),
  .key_event_gated(key_event_gated), .touch_event_gated(touch_event_gated),
  .cmd(cmd), .activity(activity), .panel_lockout(panel_lockout));
`default_nettype wire

// File: test/plc_model.sv
// Controller model driving the isolated control pins
`timescale 1ns/1ps
`default_nettype none
module plc_model
  import ext_input_pkg::*;
(
  input wire logic    aclk,
  output var ext_inputs_s ext_in
);
  initial ext_in = '0;
  // Levels held well past the synchroniser so no edge is missed
  task automatic pulse(input int b);
    @(posedge aclk);
    ext_in[b] <= 1'b1;
    repeat (8) @(posedge aclk);
    ext_in[b] <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : pulse
  task automatic code(input logic [2:0] c);
    @(posedge aclk);
    ext_in.panel_select <= c;
    repeat (2) @(posedge aclk);
  endtask : code
  task automatic lock(input logic v);
    @(posedge aclk);
    ext_in.lockout <= v;
    repeat (6) @(posedge aclk);
  endtask : lock
endmodule : plc_model
`default_nettype wire
